// file: src/ahp_host_port.sv
// parallel host port of a 12-bit successive approximation converter
//
// Contract
// - when a conversion ends and its result is ready, the done output goes low.
// - with chip select low, a falling read strobe starts a read that drives the result.
// - in internal acquisition mode a rising write strobe stores the config byte and, for top config bits 10 or 11, runs acquisition then conversion.
// - in external acquisition mode the next rising write strobe after the one that started it ends acquisition and starts conversion.
// - while chip select is high all twelve data lines are released.
// - the config byte arrives on the eight low bidirectional lines, the upper four only drive.
// - config bit 5 picks internally timed acquisition at 0 and write-strobe ended at 1.
// - top config bits 00 and 01 power down keeping the clock mode, 10 and 11 run on internal or external clock.
`timescale 1ns/10ps
module ahp_host_port
  import ahp_pkg::*;
#(
  parameter int ACQ_N = ahp_pkg::ACQ_CYCLES,
  parameter int CONV_N = ahp_pkg::CONV_TICKS,
  parameter int DIV_N = ahp_pkg::INT_DIV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // host strobes and conversion clock pin
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_ext_clk,
  // parallel data bus, low byte two-way, upper nibble drive only
  input wire logic [ahp_pkg::CFG_W-1:0] i_data,
  output logic [ahp_pkg::DATA_W-1:0] o_data,
  output logic [ahp_pkg::DATA_W-1:0] o_data_oe,
  // conversion done, active low
  output logic o_done_n,
  // analog side
  input wire logic [ahp_pkg::DATA_W-1:0] i_sample,
  output logic [1:0] o_power_mode,
  output logic o_ext_clk_mode,
  output logic [ahp_pkg::CFG_ANA_HI:0] o_analog_cfg
);
  import ahp_pkg::*;

  // three sample stages: two settle the pins, the third gives the edge
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [CFG_W-1:0] cfg;
    logic ext_clk_mode;
    logic done_n;
    logic read_act;
    logic [DATA_W-1:0] dout;
  } ahp_port_t;

  // edge tests on the sampled pin vector
  function automatic logic fell(input logic [PIN_W-1:0] old_v, input logic [PIN_W-1:0] new_v,
                                input int idx);
    fell = old_v[idx] && !new_v[idx];
  endfunction

  function automatic logic rose(input logic [PIN_W-1:0] old_v, input logic [PIN_W-1:0] new_v,
                                input int idx);
    rose = !old_v[idx] && new_v[idx];
  endfunction

  ahp_port_t q;
  ahp_port_t d;
  ahp_conv_if cif ();

  // decoded strobe events and the byte they carry
  logic cs_lo;
  logic rd_fall;
  logic wr_rise;
  logic [CFG_W-1:0] wr_byte;
  logic [1:0] new_pwr;
  logic new_mode;

  // edges only from the second and third stages
  assign cs_lo = !q.s2[PIN_CS];
  assign rd_fall = fell(q.s3, q.s2, PIN_RD);
  assign wr_rise = rose(q.s3, q.s2, PIN_WR);
  // byte sampled together with the strobe, taken while it was still low
  assign wr_byte = q.s3[PIN_DAT +: CFG_W];
  assign new_pwr = wr_byte[CFG_PWR_HI:CFG_PWR_LO];
  // power-down codes leave the clock mode as it was
  assign new_mode = new_pwr[1] ? (new_pwr == PWR_NORM_EXT) : q.ext_clk_mode;

  always_comb begin
    d = q;
    cif.start = 1'b0;
    cif.end_acq = 1'b0;
    cif.acq_ext = wr_byte[CFG_ACQ_BIT];
    cif.clk_ext = new_mode;
    // the pin clock is sampled, so only its falling edges count as ticks
    cif.ext_fall = fell(q.s3, q.s2, PIN_XCLK);
    if (i_clk_en) begin
      d.s1 = {i_data, i_ext_clk, i_wr_n, i_rd_n, i_cs_n};
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (wr_rise && cs_lo) begin
        if (cif.acq_wait) begin
          cif.end_acq = 1'b1;
        end else if (!cif.busy) begin
          d.cfg = wr_byte;
          d.ext_clk_mode = new_mode;
          cif.start = new_pwr[1];
        end
        // writes during a conversion are ignored; the host must hold off
      end
      // result copied at read start so a later conversion cannot tear it
      if (rd_fall && cs_lo) begin
        d.read_act = 1'b1;
        d.dout = cif.result;
      end else if (!cs_lo || q.s2[PIN_RD]) begin
        d.read_act = 1'b0;
      end
      // a finishing conversion wins over a read in the same cycle
      if (cif.done) begin
        d.done_n = 1'b0;
      end else if (rd_fall && cs_lo) begin
        d.done_n = 1'b1;
      end
    end
  end

  // stages reset to idle pin levels so no false strobe edge follows reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, cfg: CFG_RST, ext_clk_mode: 1'b0,
             done_n: 1'b1, read_act: 1'b0, dout: '0};
    end else begin
      q <= d;
    end
  end

  // the sequencer shares the enable, so a frozen port freezes the conversion too
  ahp_conv_core #(
    .ACQ_N(ACQ_N),
    .CONV_N(CONV_N),
    .DIV_N(DIV_N)
  ) u_core (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_sample(i_sample),
    .cif(cif.core)
  );

  // bus is released the moment the synchronised select goes high
  assign o_data_oe = {DATA_W{q.read_act && cs_lo}};
  assign o_data = q.dout;
  assign o_done_n = q.done_n;
  assign o_power_mode = q.cfg[CFG_PWR_HI:CFG_PWR_LO];
  assign o_ext_clk_mode = q.ext_clk_mode;
  assign o_analog_cfg = q.cfg[CFG_ANA_HI:0];

  // checks below all run on the port clock
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_done_goes_low: assert property (i_clk_en && cif.done |=> !o_done_n)
    else $error("done output not low after conversion");
  a_read_drives_bus: assert property (
    i_clk_en && rd_fall && cs_lo |=> o_data == $past(cif.result) && q.read_act)
    else $error("read did not drive the result");
  a_cfg_captured: assert property (
    i_clk_en && wr_rise && cs_lo && !cif.busy |=> q.cfg == $past(wr_byte))
    else $error("config byte not captured on write");
  a_ext_acq_write: assert property (
    i_clk_en && wr_rise && cs_lo && cif.acq_wait |=> $stable(q.cfg) && cif.busy)
    else $error("ending write changed config or stopped conversion");
  a_bus_released: assert property (
    (i_cs_n && i_clk_en) [*3] |=> o_data_oe == '0)
    else $error("data bus driven while deselected");
  a_cfg_only_on_write: assert property (
    $changed(q.cfg) |-> $past(i_clk_en && wr_rise && cs_lo))
    else $error("config changed without a write strobe");
  a_power_down_keeps: assert property (
    i_clk_en && wr_rise && cs_lo && !cif.busy && !new_pwr[1]
    |-> !cif.start ##1 $stable(q.ext_clk_mode))
    else $error("power-down write started a conversion or changed clock mode");
  a_done_release: assert property (
    i_clk_en && rd_fall && cs_lo && !cif.done |=> o_done_n)
    else $error("done output not released by read");

  // refused strobes leave config and read data alone
  a_busy_write_ignored: assert property (
    i_clk_en && wr_rise && cs_lo && cif.busy && !cif.acq_wait
    |=> $stable(q.cfg) && $stable(q.ext_clk_mode))
    else $error("write during a conversion changed the config");
  a_deselect_no_read: assert property (
    i_clk_en && rd_fall && !cs_lo |=> $stable(q.dout) && o_data_oe == '0)
    else $error("read strobe acted while deselected");

  // run codes start a conversion in the clock mode they name
  a_run_code_starts: assert property (
    i_clk_en && wr_rise && cs_lo && !cif.busy && new_pwr[1]
    |-> cif.start ##1 (q.ext_clk_mode == q.cfg[CFG_PWR_LO] && cif.busy))
    else $error("run code did not start a conversion in its clock mode");

  // done and bus drive only move on their own events
  a_done_only_on_end: assert property ($fell(o_done_n) |-> $past(cif.done))
    else $error("done output fell without a finished conversion");
  a_done_stays_low: assert property (
    i_clk_en && !o_done_n && !(rd_fall && cs_lo) |=> !o_done_n)
    else $error("done output rose without a read");
  a_read_ends: assert property (
    i_clk_en && (q.s2[PIN_RD] || !cs_lo) |=> !q.read_act && o_data_oe == '0)
    else $error("bus still driven after read strobe or select rose");
  a_frozen_state: assert property (
    !i_clk_en |=> $stable(q.cfg) && $stable(q.done_n) && $stable(q.read_act))
    else $error("state moved while the clock enable was low");

  // main scenarios the bench should reach

  c_read_cycle: cover property (rd_fall && cs_lo && !o_done_n);
  c_power_down: cover property (wr_rise && cs_lo && new_pwr == PWR_STANDBY);
  c_ext_clk_conv: cover property (cif.done && q.ext_clk_mode);
  c_done_and_read: cover property (cif.done && rd_fall && cs_lo);
endmodule

// file: pkg/ahp_pkg.sv
// constants and types of the adc parallel host port
package ahp_pkg;
  localparam int DATA_W = 12;
  localparam int CFG_W = 8;
  localparam int CNT_W = 16;
  // configuration byte fields
  localparam int CFG_PWR_HI = 7;
  localparam int CFG_PWR_LO = 6;
  localparam int CFG_ACQ_BIT = 5;
  localparam int CFG_ANA_HI = 4;
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_NORM_INT = 2'h2;
  localparam logic [1:0] PWR_NORM_EXT = 2'h3;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h80;
  // pin sample vector: {data[7:0], ext clk, wr_n, rd_n, cs_n}
  localparam int PIN_CS = 0;
  localparam int PIN_RD = 1;
  localparam int PIN_WR = 2;
  localparam int PIN_XCLK = 3;
  localparam int PIN_DAT = 4;
  localparam int PIN_W = 12;
  localparam logic [PIN_W-1:0] SYNC_RST = 12'h007;
  // timing counts in i_clk cycles or conversion clock ticks
  localparam int ACQ_CYCLES = 12;
  localparam int CONV_TICKS = 13;
  localparam int INT_DIV = 8;
  typedef enum logic [1:0] {AHP_IDLE, AHP_ACQ_INT, AHP_ACQ_EXT, AHP_CONV} ahp_conv_st_t;
endpackage

// file: pkg/ahp_conv_if.sv
// link between the host port and the conversion sequencer
`timescale 1ns/10ps
interface ahp_conv_if;
  import ahp_pkg::*;
  logic start;
  logic acq_ext;
  logic clk_ext;
  logic end_acq;
  logic ext_fall;
  logic done;
  logic busy;
  logic acq_wait;
  logic [DATA_W-1:0] result;
  modport ctl (output start, acq_ext, clk_ext, end_acq, ext_fall,
               input done, busy, acq_wait, result);
  modport core (input start, acq_ext, clk_ext, end_acq, ext_fall,
                output done, busy, acq_wait, result);
endinterface

// file: src/ahp_conv_core.sv
// acquisition and conversion sequencer of the adc parallel host port
`timescale 1ns/10ps
module ahp_conv_core
  import ahp_pkg::*;
#(
  parameter int ACQ_N = ahp_pkg::ACQ_CYCLES,
  parameter int CONV_N = ahp_pkg::CONV_TICKS,
  parameter int DIV_N = ahp_pkg::INT_DIV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // converter value from the analog side
  input wire logic [ahp_pkg::DATA_W-1:0] i_sample,
  // link to the host port
  ahp_conv_if.core cif
);
  import ahp_pkg::*;

  typedef struct packed {
    ahp_conv_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] div;
    logic ext;
    logic done;
    logic [DATA_W-1:0] result;
  } ahp_core_t;

  ahp_core_t q;
  ahp_core_t d;
  logic tick;

  // external clock ticks on its falling edge, internal one from a divider
  assign tick = q.ext ? cif.ext_fall : (q.div == CNT_W'(DIV_N - 1));

  always_comb begin
    d = q;
    if (i_clk_en) begin
      d.done = 1'b0;
      unique case (q.st)
        AHP_IDLE: begin
          if (cif.start) begin
            d.ext = cif.clk_ext;
            d.cnt = '0;
            d.div = '0;
            d.st = cif.acq_ext ? AHP_ACQ_EXT : AHP_ACQ_INT;
          end
        end
        AHP_ACQ_INT: begin
          d.cnt = q.cnt + 1'b1;
          if (q.cnt == CNT_W'(ACQ_N - 1)) begin
            d.cnt = '0;
            d.st = AHP_CONV;
          end
        end
        AHP_ACQ_EXT: begin
          if (cif.end_acq) begin
            d.st = AHP_CONV;
          end
        end
        AHP_CONV: begin
          d.div = tick ? '0 : q.div + 1'b1;
          if (tick) begin
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == CNT_W'(CONV_N - 1)) begin
              d.result = i_sample;
              d.done = 1'b1;
              d.st = AHP_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '{st: AHP_IDLE, cnt: '0, div: '0, ext: 1'b0, done: 1'b0, result: '0};
    end else begin
      q <= d;
    end
  end

  assign cif.done = q.done;
  assign cif.busy = (q.st != AHP_IDLE);
  assign cif.acq_wait = (q.st == AHP_ACQ_EXT);
  assign cif.result = q.result;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_result_on_done: assert property (
    i_clk_en && q.st == AHP_CONV && tick && q.cnt == CNT_W'(CONV_N - 1)
    |=> cif.done && cif.result == $past(i_sample) && !cif.busy)
    else $error("conversion end did not present result");
  a_ext_acq_end: assert property (
    i_clk_en && q.st == AHP_ACQ_EXT && cif.end_acq |=> q.st == AHP_CONV && q.cnt == '0)
    else $error("write strobe did not end external acquisition");
  a_acq_method_sel: assert property (
    i_clk_en && q.st == AHP_IDLE && cif.start
    |=> q.st == ($past(cif.acq_ext) ? AHP_ACQ_EXT : AHP_ACQ_INT))
    else $error("acquisition method not taken from config bit");
  a_int_acq_length: assert property (
    i_clk_en && q.st == AHP_ACQ_INT && q.cnt == CNT_W'(ACQ_N - 1) |=> q.st == AHP_CONV)
    else $error("internal acquisition did not end on time");
  c_ext_conversion: cover property (q.st == AHP_ACQ_EXT ##[1:200] q.st == AHP_CONV);
endmodule

// file: tb/ahp_host_model.sv
// host processor model driving the strobes of the adc parallel host port
`timescale 1ns/10ps
module ahp_host_model (
  // clock
  input wire logic i_clk,
  // strobes and conversion clock pin
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_ext_clk,
  // low byte driven toward the device
  output logic [7:0] o_data
);
  logic ext_run;
  logic [1:0] div_q;
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_ext_clk = 1'b0;
    o_data = 8'h00;
    ext_run = 1'b0;
    div_q = 2'h0;
  end
  // pin stands still unless a scenario runs the external clock
  always @(posedge i_clk) begin
    if (ext_run) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        o_ext_clk <= ~o_ext_clk;
      end
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic clk_run(input logic on);
    @(posedge i_clk);
    ext_run <= on;
  endtask
  // three- and four-cycle phases so the three-stage sampling sees every change
  task automatic write_cfg(input logic [7:0] cfg, input logic cs_n);
    @(posedge i_clk);
    o_cs_n <= cs_n;
    o_data <= cfg;
    idle(3);
    o_wr_n <= 1'b0;
    idle(4);
    o_wr_n <= 1'b1;
    idle(4);
    o_cs_n <= 1'b1;
    o_data <= ~cfg;
    idle(3);
  endtask
  task automatic read_begin(input logic cs_n);
    @(posedge i_clk);
    o_cs_n <= cs_n;
    idle(3);
    o_rd_n <= 1'b0;
    idle(6);
  endtask
  task automatic read_end();
    @(posedge i_clk);
    o_rd_n <= 1'b1;
    o_cs_n <= 1'b1;
    idle(6);
  endtask
endmodule

// file: tb/adc_parallel_host_port_tb.sv
// self-checking bench of the adc parallel host port
`timescale 1ns/10ps
module adc_parallel_host_port_tb;
  import ahp_pkg::*;
  logic clk, rst, clk_en, cs_n, rd_n, wr_n, xclk, done_n, ext_mode;
  logic [CFG_W-1:0] h_data, bus_lo;
  logic [DATA_W-1:0] sample, d_out, d_oe;
  logic [1:0] pmode;
  logic [CFG_ANA_HI:0] ana;
  int miscompares, checked, cycles;
  // the device wins the low byte whenever it drives
  assign bus_lo = d_oe[0] ? d_out[CFG_W-1:0] : h_data;
  ahp_host_port u_ahp_host_port (
    .i_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_ext_clk(xclk), .i_data(bus_lo), .o_data(d_out), .o_data_oe(d_oe),
    .o_done_n(done_n), .i_sample(sample), .o_power_mode(pmode),
    .o_ext_clk_mode(ext_mode), .o_analog_cfg(ana));
  ahp_host_model u_ahp_host_model (.i_clk(clk), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_ext_clk(xclk), .o_data(h_data));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string name, input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cfg_chk(input logic [1:0] pm, input logic em, input logic [4:0] an);
    @(negedge clk);
    chk("power mode", {10'h0, pmode}, {10'h0, pm});
    chk("clock mode", {11'h0, ext_mode}, {11'h0, em});
    chk("analog cfg", {7'h0, ana}, {7'h0, an});
  endtask
  // bounded wait; a done output still high after the limit counts as a mismatch
  task automatic wait_done(input int limit);
    int n;
    n = 0;
    while (done_n !== 1'b0 && n < limit) begin
      @(negedge clk);
      n++;
    end
    chk("done low", {11'h0, done_n}, 12'h000);
  endtask
  task automatic read_check(input logic [DATA_W-1:0] exp);
    u_ahp_host_model.read_begin(1'b0);
    @(negedge clk);
    chk("read data", d_out, exp);
    chk("drive enable", d_oe, 12'hfff);
    chk("done release", {11'h0, done_n}, 12'h001);
    u_ahp_host_model.read_end();
    @(negedge clk);
    chk("bus release", d_oe, 12'h000);
  endtask
  task automatic no_done(input int n);
    repeat (n) @(negedge clk);
    chk("done held", {11'h0, done_n}, 12'h001);
  endtask
  task automatic t_int_conv();
    @(posedge clk);
    sample <= 12'h5a3;
    u_ahp_host_model.write_cfg(8'h95, 1'b0);
    cfg_chk(2'h2, 1'b0, 5'h15);
    wait_done(200);
    read_check(12'h5a3);
  endtask
  task automatic t_ext_acq();
    @(posedge clk);
    sample <= 12'hc3c;
    u_ahp_host_model.write_cfg(8'ha3, 1'b0);
    no_done(40);
    u_ahp_host_model.write_cfg(8'h00, 1'b0);
    cfg_chk(2'h2, 1'b0, 5'h03);
    u_ahp_host_model.write_cfg(8'hff, 1'b0);
    cfg_chk(2'h2, 1'b0, 5'h03);
    wait_done(200);
    read_check(12'hc3c);
  endtask
  // conversion must wait for ticks on the clock pin
  task automatic t_ext_clk();
    @(posedge clk);
    sample <= 12'h7e1;
    u_ahp_host_model.write_cfg(8'hc0, 1'b0);
    cfg_chk(2'h3, 1'b1, 5'h00);
    no_done(60);
    u_ahp_host_model.clk_run(1'b1);
    wait_done(400);
    u_ahp_host_model.clk_run(1'b0);
    read_check(12'h7e1);
  endtask
  task automatic t_power_cs();
    u_ahp_host_model.write_cfg(8'h00, 1'b0);
    cfg_chk(2'h0, 1'b1, 5'h00);
    no_done(60);
    u_ahp_host_model.write_cfg(8'h4a, 1'b0);
    cfg_chk(2'h1, 1'b1, 5'h0a);
    u_ahp_host_model.write_cfg(8'h9f, 1'b1);
    cfg_chk(2'h1, 1'b1, 5'h0a);
    u_ahp_host_model.read_begin(1'b1);
    @(negedge clk);
    chk("deselected drive", d_oe, 12'h000);
    u_ahp_host_model.read_end();
  endtask
  // second reset in mid-run must bring back the reset config
  task automatic t_mid_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    cfg_chk(2'h2, 1'b0, 5'h00);
    chk("mid reset done", {11'h0, done_n}, 12'h001);
    chk("mid reset drive", d_oe, 12'h000);
  endtask
  // a low clock enable must stall a running conversion
  task automatic t_freeze();
    @(posedge clk);
    sample <= 12'h3c5;
    u_ahp_host_model.write_cfg(8'h91, 1'b0);
    cfg_chk(2'h2, 1'b0, 5'h11);
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (300) @(posedge clk);
    @(negedge clk);
    chk("frozen done", {11'h0, done_n}, 12'h001);
    @(posedge clk);
    clk_en <= 1'b1;
    wait_done(200);
    read_check(12'h3c5);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    sample = 12'h000;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("reset done", {11'h0, done_n}, 12'h001);
    chk("reset drive", d_oe, 12'h000);
    cfg_chk(2'h2, 1'b0, 5'h00);
    t_int_conv();
    t_ext_acq();
    t_ext_clk();
    t_power_cs();
    t_mid_reset();
    t_freeze();
    close_out();
  end
endmodule
